// ==== rtl/vpa_pkg.sv ====
// Constants for the picture adjust register bank: sub addresses, reset values,
// write masks, field positions and brightness scale factors.
// Assumes the users refer to every name with the package prefix.
package vpa_pkg;

  // Sub addresses
  localparam logic [7:0] SPLIT_ADDR = 8'h10;
  localparam logic [7:0] KILL_ADDR  = 8'h11;
  localparam logic [7:0] OFFS_ADDR  = 8'h12;
  localparam logic [7:0] GAIN_ADDR  = 8'h13;
  localparam logic [7:0] CGAIN_ADDR = 8'h14;

  // Reset values
  localparam logic [7:0] SPLIT_RST = 8'h06;
  localparam logic [7:0] KILL_RST  = 8'had;
  localparam logic [7:0] OFFS_RST  = 8'h00;
  localparam logic [7:0] GAIN_RST  = 8'h80;
  localparam logic [7:0] CGAIN_RST = 8'h80;

  // Writable bits; reserved bits hold zero
  localparam logic [7:0] SPLIT_MASK = 8'h0f;
  localparam logic [7:0] KILL_MASK  = 8'hbf;
  localparam logic [7:0] FULL_MASK  = 8'hff;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // Field positions
  localparam int SPLIT_LSB   = 0;
  localparam int SPLIT_MSB   = 1;
  localparam int BPF_LSB     = 2;
  localparam int BPF_MSB     = 3;
  localparam int THR_LSB     = 0;
  localparam int THR_MSB     = 5;
  localparam int KILL_EN_BIT = 7;

  // Separation and band-pass codes
  localparam logic [1:0] SPLIT_2D       = 2'h0;
  localparam logic [1:0] SPLIT_1D       = 2'h1;
  localparam logic [1:0] SPLIT_ADAPTIVE = 2'h2;
  localparam logic [1:0] BPF_WIDE       = 2'h1;
  localparam logic [1:0] BPF_MIDDLE     = 2'h2;
  localparam logic [1:0] BPF_NARROW     = 2'h3;

  // Brightness scale numerators over a common divisor
  localparam logic [6:0] BR_286_PLAIN = 7'h64;
  localparam logic [6:0] BR_286_SETUP = 7'h6c;
  localparam logic [6:0] BR_300_PLAIN = 7'h66;
  localparam logic [6:0] BR_300_SETUP = 7'h6f;
  localparam logic [14:0] BR_DIVISOR  = 15'h00ff;

  // Gain code for unity: code / 2^GAIN_SHIFT
  localparam int GAIN_SHIFT = 7;

  // Luma sample limits
  localparam logic signed [11:0] LUMA_MIN = 12'sh000;
  localparam logic signed [11:0] LUMA_MAX = 12'sh3ff;

endpackage : vpa_pkg

// ==== rtl/vpa_gain.sv ====
// Signed sample times an 8-bit gain code over 2^GAIN_SHIFT, saturated.
// Assumes a combinational context; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module vpa_gain #(
  parameter int W = 10
) (
  input  wire logic signed [W-1:0] sample_in,  // Input sample
  input  wire logic        [7:0]   code_in,    // Gain code
  output logic signed      [W-1:0] sample_out  // Scaled sample
);

  localparam logic signed [W+8:0] POS_LIM = (W+9)'((1 << (W-1)) - 1);
  localparam logic signed [W+8:0] NEG_LIM = -(W+9)'(1 << (W-1));

  wire logic signed [W+8:0] prod_w;
  wire logic signed [W+8:0] shifted_w;

  // Widen both operands first so the product is not cut to the sample width
  assign prod_w    = (W+9)'(sample_in) * (W+9)'($signed({1'b0, code_in}));
  assign shifted_w = prod_w >>> vpa_pkg::GAIN_SHIFT;
  assign sample_out = (shifted_w > POS_LIM) ? POS_LIM[W-1:0] :
                      (shifted_w < NEG_LIM) ? NEG_LIM[W-1:0] : shifted_w[W-1:0];

endmodule : vpa_gain
`default_nettype wire

// ==== rtl/vpa_regs.sv ====
// Picture adjust register bank with the luma and chroma adjust stage it drives.
// Assumes a sub-address write/read port from the serial control front end on
// sys_clk_in, video samples on the same clock, and two slow strap pins.
`timescale 1ns/10ps
`default_nettype none
module vpa_regs #(
  parameter int LUMA_W  = 10,
  parameter int CHROMA_W = 10,
  parameter int BURST_W = 9
) (
  input  wire logic                       sys_clk_in,       // 40 MHz clock
  input  wire logic                       rst_in,           // Sync reset, high
  input  wire logic                       wr_en_in,         // Register write strobe
  input  wire logic                       rd_en_in,         // Register read strobe
  input  wire logic [7:0]                 sub_addr_in,      // Sub address
  input  wire logic [7:0]                 wr_data_in,       // Write data
  output logic      [7:0]                 rd_data_out,      // Read data
  output logic                            rd_valid_out,     // Read data valid
  input  wire logic                       sync_300mv_in,    // Strap: -300 mV sync
  input  wire logic                       setup_in,         // Strap: setup present
  input  wire logic                       sample_valid_in,  // Sample strobe
  input  wire logic [LUMA_W-1:0]          luma_in,          // Luma sample
  input  wire logic signed [CHROMA_W-1:0] chroma_in,        // Chroma sample
  input  wire logic [BURST_W-1:0]         burst_amp_in,     // Measured burst
  output logic                            sample_valid_out, // Output strobe
  output logic      [LUMA_W-1:0]          luma_out,         // Adjusted luma
  output logic signed [CHROMA_W-1:0]      chroma_out,       // Adjusted chroma
  output logic                            chroma_killed_out,// Killer active
  output logic      [1:0]                 split_method_sel_out,    // Separation mode
  output logic      [1:0]                 chroma_bandpass_sel_out  // Band-pass select
);

  logic [7:0] luma_chroma_split_ctrl_reg;
  logic [7:0] chroma_kill_ctrl_reg;
  logic [7:0] luma_offset_level_reg;
  logic [7:0] luma_gain_level_reg;
  logic [7:0] chroma_gain_level_reg;
  logic [7:0] rd_data_reg;
  logic       rd_valid_reg;
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;
  logic [1:0] strap_s3_reg;
  logic [1:0] strap_reg;
  logic                       valid_reg;
  logic [LUMA_W-1:0]          luma_reg;
  logic signed [CHROMA_W-1:0] chroma_reg;
  logic                       killed_reg;

  wire logic                        hit_split_w;
  wire logic                        hit_kill_w;
  wire logic                        hit_offs_w;
  wire logic                        hit_gain_w;
  wire logic                        hit_cgain_w;
  wire logic [7:0]                  rd_mux_w;
  wire logic                        chroma_kill_enable;
  wire logic [5:0]                  chroma_kill_threshold;
  wire logic [6:0]                  offset_scale_w;
  wire logic [14:0]                 offset_prod_w;
  wire logic [6:0]                  offset_w;
  wire logic signed [LUMA_W:0]      luma_gained_w;
  wire logic signed [11:0]          luma_sum_w;
  wire logic signed [CHROMA_W-1:0]  chroma_gained_w;
  wire logic                        kill_now_w;
  wire logic [1:0]                  strap_next;

  function automatic logic [LUMA_W-1:0] clamp_luma(input logic signed [11:0] v);
    if (v < vpa_pkg::LUMA_MIN) begin
      clamp_luma = '0;
    end else if (v > vpa_pkg::LUMA_MAX) begin
      clamp_luma = vpa_pkg::LUMA_MAX[LUMA_W-1:0];
    end else begin
      clamp_luma = v[LUMA_W-1:0];
    end
  endfunction : clamp_luma

  // Address decode
  assign hit_split_w = (sub_addr_in == vpa_pkg::SPLIT_ADDR);
  assign hit_kill_w  = (sub_addr_in == vpa_pkg::KILL_ADDR);
  assign hit_offs_w  = (sub_addr_in == vpa_pkg::OFFS_ADDR);
  assign hit_gain_w  = (sub_addr_in == vpa_pkg::GAIN_ADDR);
  assign hit_cgain_w = (sub_addr_in == vpa_pkg::CGAIN_ADDR);

  assign rd_mux_w = hit_split_w ? luma_chroma_split_ctrl_reg :
                    hit_kill_w  ? chroma_kill_ctrl_reg :
                    hit_offs_w  ? luma_offset_level_reg :
                    hit_gain_w  ? luma_gain_level_reg :
                    hit_cgain_w ? chroma_gain_level_reg : vpa_pkg::UNMAPPED_DATA;

  // Register file; reserved bits are masked on every write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      luma_chroma_split_ctrl_reg <= vpa_pkg::SPLIT_RST;
      chroma_kill_ctrl_reg       <= vpa_pkg::KILL_RST;
      luma_offset_level_reg      <= vpa_pkg::OFFS_RST;
      luma_gain_level_reg        <= vpa_pkg::GAIN_RST;
      chroma_gain_level_reg      <= vpa_pkg::CGAIN_RST;
    end else if (wr_en_in) begin
      if (hit_split_w) luma_chroma_split_ctrl_reg <= wr_data_in & vpa_pkg::SPLIT_MASK;
      if (hit_kill_w)  chroma_kill_ctrl_reg       <= wr_data_in & vpa_pkg::KILL_MASK;
      if (hit_offs_w)  luma_offset_level_reg      <= wr_data_in & vpa_pkg::FULL_MASK;
      if (hit_gain_w)  luma_gain_level_reg        <= wr_data_in & vpa_pkg::FULL_MASK;
      if (hit_cgain_w) chroma_gain_level_reg      <= wr_data_in & vpa_pkg::FULL_MASK;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_data_reg  <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en_in;
      if (rd_en_in) rd_data_reg <= rd_mux_w;
    end
  end

  assign rd_data_out  = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;

  // Mode fields go straight to the separation filter; reserved codes pass as written
  assign split_method_sel_out    = luma_chroma_split_ctrl_reg[vpa_pkg::SPLIT_MSB:vpa_pkg::SPLIT_LSB];
  assign chroma_bandpass_sel_out = luma_chroma_split_ctrl_reg[vpa_pkg::BPF_MSB:vpa_pkg::BPF_LSB];

  // Strap pins: three stages, accepted once the last two agree
  assign strap_next = (strap_s2_reg == strap_s3_reg) ? strap_s3_reg : strap_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      strap_s1_reg <= 2'h0;
      strap_s2_reg <= 2'h0;
      strap_s3_reg <= 2'h0;
      strap_reg    <= 2'h0;
    end else begin
      strap_s1_reg <= {sync_300mv_in, setup_in};
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      strap_reg    <= strap_next;
    end
  end

  // Brightness offset in luma LSBs
  assign offset_scale_w = strap_reg[1] ? (strap_reg[0] ? vpa_pkg::BR_300_SETUP : vpa_pkg::BR_300_PLAIN)
                                       : (strap_reg[0] ? vpa_pkg::BR_286_SETUP : vpa_pkg::BR_286_PLAIN);
  assign offset_prod_w  = 15'(luma_offset_level_reg) * 15'(offset_scale_w);
  assign offset_w       = 7'(offset_prod_w / vpa_pkg::BR_DIVISOR);

  vpa_gain #(.W(LUMA_W + 1)) u_luma_gain (
    .sample_in  ($signed({1'b0, luma_in})),
    .code_in    (luma_gain_level_reg),
    .sample_out (luma_gained_w)
  );

  vpa_gain #(.W(CHROMA_W)) u_chroma_gain (
    .sample_in  (chroma_in),
    .code_in    (chroma_gain_level_reg),
    .sample_out (chroma_gained_w)
  );

  assign luma_sum_w = 12'(luma_gained_w) + $signed({5'h00, offset_w});

  // Killer: higher threshold code demands a stronger burst
  assign chroma_kill_enable    = chroma_kill_ctrl_reg[vpa_pkg::KILL_EN_BIT];
  assign chroma_kill_threshold = chroma_kill_ctrl_reg[vpa_pkg::THR_MSB:vpa_pkg::THR_LSB];
  assign kill_now_w = chroma_kill_enable && (burst_amp_in < BURST_W'(chroma_kill_threshold));

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      valid_reg  <= 1'b0;
      luma_reg   <= '0;
      chroma_reg <= '0;
      killed_reg <= 1'b0;
    end else begin
      valid_reg <= sample_valid_in;
      if (sample_valid_in) begin
        luma_reg   <= clamp_luma(luma_sum_w);
        chroma_reg <= kill_now_w ? '0 : chroma_gained_w;
        killed_reg <= kill_now_w;
      end
    end
  end

  assign sample_valid_out  = valid_reg;
  assign luma_out          = luma_reg;
  assign chroma_out        = chroma_reg;
  assign chroma_killed_out = killed_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_write_split;
    wr_en_in && !rd_en_in && hit_split_w;
  endsequence
  sequence s_read_split;
    rd_en_in && !wr_en_in && hit_split_w;
  endsequence
  sequence s_split_idle;
    !(wr_en_in && hit_split_w);
  endsequence

  a_split_reset_value: assert property ($past(rst_in) |-> luma_chroma_split_ctrl_reg == vpa_pkg::SPLIT_RST)
    else $error("split register not at reset value");
  a_split_reserved_zero: assert property (luma_chroma_split_ctrl_reg[7:4] == 4'h0)
    else $error("split register reserved bits set");
  a_split_write_read: assert property (s_write_split ##1 s_split_idle ##1 s_read_split |=>
      rd_valid_out && rd_data_out == ($past(wr_data_in, 3) & vpa_pkg::SPLIT_MASK))
    else $error("split register readback wrong");
  a_kill_reset_value: assert property ($past(rst_in) |-> chroma_kill_ctrl_reg == vpa_pkg::KILL_RST)
    else $error("kill register not at reset value");
  a_kill_bit_reserved: assert property (chroma_kill_ctrl_reg[6] == 1'b0)
    else $error("kill register reserved bit set");
  a_kill_forces_zero: assert property (sample_valid_in && chroma_kill_enable &&
      burst_amp_in < BURST_W'(chroma_kill_threshold) |=> chroma_out == '0 && chroma_killed_out)
    else $error("chroma not killed below threshold");
  a_kill_disabled_pass: assert property (sample_valid_in && !chroma_kill_enable |=> !chroma_killed_out)
    else $error("killer acted while disabled");
  a_luma_unity_path: assert property (sample_valid_in && luma_offset_level_reg == 8'h00 &&
      luma_gain_level_reg == vpa_pkg::GAIN_RST |=> luma_out == $past(luma_in))
    else $error("luma changed at neutral settings");
  a_luma_offset_add: assert property (sample_valid_in && luma_gain_level_reg == vpa_pkg::GAIN_RST &&
      !luma_in[LUMA_W-1] |=> luma_out == $past(luma_in) + LUMA_W'($past(offset_w)))
    else $error("luma offset not applied");
  a_chroma_unity_path: assert property (sample_valid_in && !kill_now_w &&
      chroma_gain_level_reg == vpa_pkg::CGAIN_RST |=> chroma_out == $past(chroma_in))
    else $error("chroma changed at unity gain");
  a_chroma_zero_gain: assert property (sample_valid_in && chroma_gain_level_reg == 8'h00 |=> chroma_out == '0)
    else $error("chroma not zero at zero gain");
  a_luma_double_gain: assert property (sample_valid_in && luma_offset_level_reg == 8'h00 &&
      luma_gain_level_reg == 8'hff && luma_in < 10'h080 |=>
      luma_out == LUMA_W'((16'($past(luma_in)) * 16'h00ff) >> vpa_pkg::GAIN_SHIFT))
    else $error("luma gain scaling wrong");

endmodule : vpa_regs
`default_nettype wire

// ==== bench/vpa_host.sv ====
// Behavioural model of the serial control host: single-byte sub-addressed writes and reads.
// Assumes one calling process and a clock shared with the register bank.
`timescale 1ns/10ps
`default_nettype none
module vpa_host (
  input  wire logic       clk_in,    // Clock
  output logic            wr_en_out, // Write strobe
  output logic            rd_en_out, // Read strobe
  output logic      [7:0] addr_out,  // Sub address
  output logic      [7:0] data_out   // Write data
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = 8'h5a;
    data_out  = 8'ha5;
  end

  // Threshold code for a kill level in dB, rounded to nearest
  function automatic logic [5:0] thr_code(input real db);
    return 6'($rtoi(448.0 * $pow(10.0, db / 20.0) + 0.5));
  endfunction : thr_code

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out  <= a;
    data_out  <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // Released lines show the inverse, never the last value
    addr_out  <= ~a;
    data_out  <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out  <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out  <= ~a;
  endtask : rd
endmodule : vpa_host
`default_nettype wire

// ==== bench/vpa_regs_tb.sv ====
// Self-checking bench for the picture adjust register bank and its adjust stage.
// Assumes the host model in vpa_host.sv; expectations come from a shadow of the registers.
`timescale 1ns/10ps
`default_nettype none
module vpa_regs_tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               wr_en, rd_en, rd_valid, sv_in = 1'b0, sv_out, killed;
  logic               s300 = 1'b0, setup = 1'b0;
  logic        [7:0]  addr, wdata, rd_data;
  logic        [9:0]  luma_in = 10'h000, luma_out;
  logic signed [9:0]  chroma_in = 10'sh000, chroma_out;
  logic        [8:0]  burst = 9'h000;
  logic        [1:0]  split_sel, bpf_sel;
  logic        [7:0]  sh [5];
  logic        [7:0]  rq [$];
  logic        [20:0] sq [$];
  logic        [31:0] seed = 32'h0001578a;
  logic        [31:0] rv;
  logic        [5:0]  thr;
  int                 fails = 0;
  int                 samples_checked = 0;

  initial forever #12.5 clk = ~clk;

  vpa_host u_vpa_host (.clk_in(clk), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .data_out(wdata));
  vpa_regs u_vpa_regs (.sys_clk_in(clk), .rst_in(rst), .wr_en_in(wr_en), .rd_en_in(rd_en), .sub_addr_in(addr),
    .wr_data_in(wdata), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .sync_300mv_in(s300), .setup_in(setup),
    .sample_valid_in(sv_in), .luma_in(luma_in), .chroma_in(chroma_in), .burst_amp_in(burst),
    .sample_valid_out(sv_out), .luma_out(luma_out), .chroma_out(chroma_out), .chroma_killed_out(killed),
    .split_method_sel_out(split_sel), .chroma_bandpass_sel_out(bpf_sel));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Reserved bits read back as zero
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    u_vpa_host.wr(a, d);
    if (a >= 8'h10 && a <= 8'h14)
      sh[a - 8'h10] = d & (a == 8'h10 ? 8'h0f : a == 8'h11 ? 8'hbf : 8'hff);
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    rq.push_back((a >= 8'h10 && a <= 8'h14) ? sh[a - 8'h10] : 8'h00);
    u_vpa_host.rd(a);
  endtask : rreg

  function automatic logic [20:0] exp_s(input logic [9:0] y, input logic signed [9:0] c, input logic [8:0] b);
    int  m;
    int  ch;
    int  kk;
    logic k;
    kk = s300 ? (setup ? 111 : 102) : (setup ? 108 : 100);
    m = (int'(y) * int'(sh[3])) >>> 7;
    m = (m > 1023) ? 1023 : m;
    m = m + (int'(sh[2]) * kk) / 255;
    m = (m > 1023) ? 1023 : m;
    ch = (int'(c) * int'(sh[4])) >>> 7;
    ch = (ch > 511) ? 511 : (ch < -512) ? -512 : ch;
    k = sh[1][7] && (int'(b) < int'(sh[1][5:0]));
    return {k, (k ? 10'h000 : 10'(ch)), 10'(m)};
  endfunction : exp_s

  task automatic smp(input logic v);
    logic [31:0] r;
    r = xs();
    @(posedge clk);
    sv_in     <= v;
    luma_in   <= r[9:0];
    chroma_in <= r[19:10];
    burst     <= {3'h0, thr} + 9'(r[21:20]) - 9'h001;
    if (v)
      sq.push_back(exp_s(r[9:0], r[19:10], {3'h0, thr} + 9'(r[21:20]) - 9'h001));
  endtask : smp

  always @(negedge clk) begin
    if (rd_valid === 1'b1)
      chk("rd_data", (rq.size() > 0) ? 21'(rq.pop_front()) : 21'h1fffff, 21'(rd_data));
    if (sv_out === 1'b1)
      chk("sample", (sq.size() > 0) ? sq.pop_front() : 21'h1fffff, {killed, chroma_out, luma_out});
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    sh = '{8'h06, 8'had, 8'h00, 8'h80, 8'h80};
    thr = 6'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("split_sel", 21'h2, 21'(split_sel));
    chk("bpf_sel", 21'h1, 21'(bpf_sel));
    chk("reset kill code", 21'(u_vpa_host.thr_code(-20.0)), 21'(u_vpa_regs.chroma_kill_ctrl_reg[5:0]));
    for (int i = 8'h0f; i <= 8'h15; i++)
      rreg(8'(i));
    for (int i = 0; i < 16; i++) begin
      rv = xs();
      wreg(8'h10, {rv[3:0], 4'(i)});
      @(negedge clk);
      chk("split_sel", 21'(i % 4), 21'(split_sel));
      chk("bpf_sel", 21'(i / 4), 21'(bpf_sel));
      rreg(8'h10);
    end
    wreg(8'h11, 8'hff);
    rreg(8'h11);
    wreg(8'h15, 8'h5a);
    rreg(8'h15);
    for (int st = 0; st < 4; st++) begin
      @(posedge clk);
      s300  <= st[1];
      setup <= st[0];
      repeat (6) @(posedge clk);
      for (int j = 0; j < 4; j++) begin
        rv = xs();
        thr = (j == 0) ? u_vpa_host.thr_code(-17.0) : rv[5:0];
        wreg(8'h11, {rv[6], 1'b0, thr});
        // Pass 1 unity gains, pass 2 double luma gain, pass 3 neutral luma and zero chroma gain
        wreg(8'h12, (j >= 2) ? 8'h00 : rv[15:8]);
        wreg(8'h13, (j == 1 || j == 3) ? 8'h80 : (j == 2) ? 8'hff : rv[23:16]);
        wreg(8'h14, (j == 1) ? 8'h80 : (j == 3) ? 8'h00 : rv[31:24]);
        for (int k = 0; k < 5; k++)
          rreg(8'h10 + 8'(k));
        repeat (8) smp(1'b1);
        smp(1'b0);
      end
    end
    for (int w = 0; w < 10 && (rq.size() + sq.size()) > 0; w++)
      @(negedge clk);
    if ((rq.size() + sq.size()) > 0)
      fails++;
    test_done();
  end
endmodule : vpa_regs_tb
`default_nettype wire
